// ==== hw/sram_pkg.sv ====
package sram_pkg;
  localparam logic [7:0]  OP_READ          = 8'h03;
  localparam logic [7:0]  OP_WRITE         = 8'h02;
  localparam logic [7:0]  OP_ENTER_TWO     = 8'h3b;
  localparam logic [7:0]  OP_ENTER_FOUR    = 8'h38;
  localparam logic [7:0]  OP_RETURN_SINGLE = 8'hff;
  localparam logic [7:0]  OP_READ_MODE     = 8'h05;
  localparam logic [7:0]  OP_WRITE_MODE    = 8'h01;
  localparam logic [1:0]  MODE_BYTE        = 2'h0;
  localparam logic [1:0]  MODE_SEQ         = 2'h1;
  localparam logic [1:0]  MODE_PAGE        = 2'h2;
  localparam int          MODE_HI_BIT      = 7;
  localparam int          MODE_LO_BIT      = 6;
  localparam logic [1:0]  MODE_RESET       = 2'h1;
  localparam int          ADDR_BITS        = 17;
  localparam int          PAGE_BITS        = 5;
  localparam int          INSTR_BITS       = 8;
  localparam int          ADDR_FIELD_BITS  = 24;
  localparam logic [16:0] ADDR_LAST        = 17'h1ffff;
  localparam logic [16:0] ADDR_FIRST       = 17'h00000;
  typedef enum logic [1:0] {WIDTH_ONE, WIDTH_TWO, WIDTH_FOUR} width_t;
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_RDATA, ST_WDATA, ST_RMODE, ST_WMODE, ST_IGNORE, ST_DONE} state_t;
endpackage : sram_pkg

// ==== hw/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_r <= rst_val;
      q      <= rst_val;
    end
    else if (ce)
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : pin_sync

// ==== hw/serial_sram_spi_slave.sv ====
`timescale 1ns/1ps
module serial_sram_spi_slave #(
  parameter int DEPTH = 131072
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       chip_select_n,
  input  wire logic       serial_clock,
  input  wire logic       wide_data_line_zero_in,
  output logic            wide_data_line_zero_out,
  output logic            wide_data_line_zero_oe,
  input  wire logic       wide_data_line_one_in,
  output logic            wide_data_line_one_out,
  output logic            wide_data_line_one_oe,
  input  wire logic       wide_data_line_two_in,
  output logic            wide_data_line_two_out,
  output logic            wide_data_line_two_oe,
  input  wire logic       wide_data_line_three_in,
  output logic            wide_data_line_three_out,
  output logic            wide_data_line_three_oe,
  output logic [1:0]      bus_width,
  output logic [1:0]      access_mode
);
  logic [5:0]                    pins_s;
  logic                          cs_n_s;
  logic                          sck_s;
  logic [3:0]                    din_s;
  logic                          sck_d_r;
  logic                          cs_d_r;
  logic                          started_r;
  sram_pkg::state_t              state_r;
  sram_pkg::width_t              width_r;
  logic [1:0]                    mode_r;
  logic [1:0]                    op_mode_r;
  logic [7:0]                    shift_r;
  logic [5:0]                    cnt_r;
  logic [sram_pkg::ADDR_BITS-1:0] addr_r;
  logic [7:0]                    out_r;
  logic                          out_act_r;
  logic [7:0]                    mem [DEPTH];
  logic                          cmd_is_read_r;
  logic                          rise;
  logic                          fall;
  logic [3:0]                    step;
  logic [7:0]                    shift_nxt;
  logic [5:0]                    cnt_nxt;
  logic                          pause;

  pin_sync #(.W(6)) u_sync (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .d       ({chip_select_n, serial_clock, wide_data_line_three_in, wide_data_line_two_in,
                wide_data_line_one_in, wide_data_line_zero_in}),
    .rst_val (6'h28),
    .q       (pins_s)
  );
  assign cs_n_s = pins_s[5];
  assign sck_s  = pins_s[4];
  assign din_s  = pins_s[3:0];

  function automatic logic [3:0] bits_per_clk(input sram_pkg::width_t w);
    unique case (w)
      sram_pkg::WIDTH_ONE: bits_per_clk = 4'h1;
      sram_pkg::WIDTH_TWO: bits_per_clk = 4'h2;
      default:             bits_per_clk = 4'h4;
    endcase
  endfunction : bits_per_clk

  function automatic logic [sram_pkg::ADDR_BITS-1:0] next_addr(input logic [sram_pkg::ADDR_BITS-1:0] a,
                                                            input logic [1:0] m);
    if (m == sram_pkg::MODE_PAGE)
      next_addr = {a[sram_pkg::ADDR_BITS-1:sram_pkg::PAGE_BITS], a[sram_pkg::PAGE_BITS-1:0] + 5'h01};
    else if (a == sram_pkg::ADDR_LAST)
      next_addr = sram_pkg::ADDR_FIRST;
    else
      next_addr = a + 17'h00001;
  endfunction : next_addr

  // serial edges are ignored while paused
  assign rise  = sck_s & ~sck_d_r & ~cs_n_s & started_r & ~pause;
  assign fall  = ~sck_s & sck_d_r & ~cs_n_s & started_r & ~pause;
  assign step  = bits_per_clk(width_r);
  assign pause = (width_r == sram_pkg::WIDTH_ONE) & ~din_s[3];

  // msb first for every width: new bits enter at the bottom
  always_comb
  begin
    unique case (width_r)
      sram_pkg::WIDTH_ONE: shift_nxt = {shift_r[6:0], din_s[0]};
      sram_pkg::WIDTH_TWO: shift_nxt = {shift_r[5:0], din_s[1:0]};
      default:             shift_nxt = {shift_r[3:0], din_s[3:0]};
    endcase
    cnt_nxt = cnt_r + {2'h0, step};
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sck_d_r   <= 1'b0;
      cs_d_r    <= 1'b1;
      started_r <= 1'b0;
    end
    else if (ce)
    begin
      sck_d_r <= sck_s;
      cs_d_r  <= cs_n_s;
      if (cs_d_r & ~cs_n_s)
        started_r <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_r   <= sram_pkg::ST_CMD;
      width_r   <= sram_pkg::WIDTH_ONE;
      mode_r    <= sram_pkg::MODE_RESET;
      op_mode_r <= sram_pkg::MODE_RESET;
      shift_r   <= 8'h00;
      cnt_r     <= 6'h00;
      addr_r    <= '0;
    end
    else if (ce)
    begin
      if (cs_n_s)
      begin
        state_r   <= sram_pkg::ST_CMD;
        cnt_r     <= 6'h00;
        op_mode_r <= mode_r;
      end
      else if (rise)
      begin
        shift_r <= shift_nxt;
        cnt_r   <= cnt_nxt;
        unique case (state_r)
          sram_pkg::ST_CMD:
            if (cnt_nxt == 6'(sram_pkg::INSTR_BITS))
            begin
              cnt_r <= 6'h00;
              unique case (shift_nxt)
                sram_pkg::OP_READ, sram_pkg::OP_WRITE: state_r <= sram_pkg::ST_ADDR;
                sram_pkg::OP_READ_MODE:                state_r <= sram_pkg::ST_RMODE;
                sram_pkg::OP_WRITE_MODE:               state_r <= sram_pkg::ST_WMODE;
                sram_pkg::OP_ENTER_TWO:
                begin
                  width_r <= sram_pkg::WIDTH_TWO;
                  state_r <= sram_pkg::ST_DONE;
                end
                sram_pkg::OP_ENTER_FOUR:
                begin
                  width_r <= sram_pkg::WIDTH_FOUR;
                  state_r <= sram_pkg::ST_DONE;
                end
                sram_pkg::OP_RETURN_SINGLE:
                begin
                  width_r <= sram_pkg::WIDTH_ONE;
                  state_r <= sram_pkg::ST_DONE;
                end
                default: state_r <= sram_pkg::ST_IGNORE;
              endcase
            end
          sram_pkg::ST_ADDR:
          begin
            if (step == 4'h1)
              addr_r <= {addr_r[sram_pkg::ADDR_BITS-2:0], din_s[0]};
            else if (step == 4'h2)
              addr_r <= {addr_r[sram_pkg::ADDR_BITS-3:0], din_s[1:0]};
            else
              addr_r <= {addr_r[sram_pkg::ADDR_BITS-5:0], din_s[3:0]};
            if (cnt_nxt == 6'(sram_pkg::ADDR_FIELD_BITS))
            begin
              cnt_r   <= 6'h00;
              state_r <= (cmd_is_read_r) ? sram_pkg::ST_RDATA : sram_pkg::ST_WDATA;
            end
          end
          sram_pkg::ST_WDATA, sram_pkg::ST_RDATA:
            if (cnt_nxt == 6'(sram_pkg::INSTR_BITS))
            begin
              cnt_r  <= 6'h00;
              addr_r <= next_addr(addr_r, op_mode_r);
              if (op_mode_r == sram_pkg::MODE_BYTE)
                state_r <= sram_pkg::ST_DONE;
            end
          sram_pkg::ST_WMODE:
            if (cnt_nxt == 6'(sram_pkg::INSTR_BITS))
            begin
              mode_r  <= shift_nxt[sram_pkg::MODE_HI_BIT:sram_pkg::MODE_LO_BIT];
              state_r <= sram_pkg::ST_DONE;
            end
          sram_pkg::ST_RMODE:
            if (cnt_nxt == 6'(sram_pkg::INSTR_BITS))
              state_r <= sram_pkg::ST_DONE;
          sram_pkg::ST_IGNORE, sram_pkg::ST_DONE:
            cnt_r <= 6'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      cmd_is_read_r <= 1'b0;
    else if (ce && rise && state_r == sram_pkg::ST_CMD && cnt_nxt == 6'(sram_pkg::INSTR_BITS))
      cmd_is_read_r <= (shift_nxt == sram_pkg::OP_READ);
  end

  // array storage and write
  always_ff @(posedge clk)
  begin
    if (ce && rstn && !cs_n_s && rise && state_r == sram_pkg::ST_WDATA
        && cnt_nxt == 6'(sram_pkg::INSTR_BITS))
      mem[addr_r] <= shift_nxt;
  end

  // output shifter: loads at the falling edge that opens a byte
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      out_r     <= 8'h00;
      out_act_r <= 1'b0;
    end
    else if (ce)
    begin
      if (cs_n_s)
        out_act_r <= 1'b0;
      else if (fall)
      begin
        if ((state_r == sram_pkg::ST_RDATA || state_r == sram_pkg::ST_RMODE) && cnt_r == 6'h00)
        begin
          out_act_r <= 1'b1;
          out_r     <= (state_r == sram_pkg::ST_RMODE) ? {mode_r, 6'h00} : mem[addr_r];
        end
        else if (out_act_r)
          out_r <= (width_r == sram_pkg::WIDTH_ONE) ? {out_r[6:0], 1'b0} :
                   (width_r == sram_pkg::WIDTH_TWO) ? {out_r[5:0], 2'h0} : {out_r[3:0], 4'h0};
        if (state_r != sram_pkg::ST_RDATA && state_r != sram_pkg::ST_RMODE && cnt_r == 6'h00)
          out_act_r <= 1'b0;
      end
    end
  end

  // pin drivers, registered
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wide_data_line_zero_out  <= 1'b0;
      wide_data_line_zero_oe   <= 1'b0;
      wide_data_line_one_out   <= 1'b0;
      wide_data_line_one_oe    <= 1'b0;
      wide_data_line_two_out   <= 1'b0;
      wide_data_line_two_oe    <= 1'b0;
      wide_data_line_three_out <= 1'b0;
      wide_data_line_three_oe  <= 1'b0;
      bus_width                <= 2'h0;
      access_mode              <= sram_pkg::MODE_RESET;
    end
    else if (ce)
    begin
      bus_width   <= width_r;
      access_mode <= mode_r;
      unique case (width_r)
        sram_pkg::WIDTH_ONE:
        begin
          wide_data_line_one_out  <= out_r[7];
          wide_data_line_one_oe   <= out_act_r & ~cs_n_s & ~pause;
          wide_data_line_zero_oe  <= 1'b0;
          wide_data_line_two_oe   <= 1'b0;
          wide_data_line_three_oe <= 1'b0;
        end
        sram_pkg::WIDTH_TWO:
        begin
          {wide_data_line_one_out, wide_data_line_zero_out} <= out_r[7:6];
          wide_data_line_one_oe   <= out_act_r & ~cs_n_s & ~pause;
          wide_data_line_zero_oe  <= out_act_r & ~cs_n_s & ~pause;
          wide_data_line_two_oe   <= 1'b0;
          wide_data_line_three_oe <= 1'b0;
        end
        default:
        begin
          {wide_data_line_three_out, wide_data_line_two_out, wide_data_line_one_out,
           wide_data_line_zero_out} <= out_r[7:4];
          wide_data_line_zero_oe  <= out_act_r & ~cs_n_s;
          wide_data_line_one_oe   <= out_act_r & ~cs_n_s;
          wide_data_line_two_oe   <= out_act_r & ~cs_n_s;
          wide_data_line_three_oe <= out_act_r & ~cs_n_s;
        end
      endcase
    end
  end

  mode_default_a: assert property (@(posedge clk) !rstn |=> mode_r == sram_pkg::MODE_RESET)
    else $error("mode not sequential after reset");
  float_cs_a: assert property (@(posedge clk) disable iff (!rstn) ce && cs_n_s |=> !wide_data_line_one_oe)
    else $error("output driven while deselected");
  idle_stay_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && state_r == sram_pkg::ST_IGNORE && !cs_n_s |=> state_r == sram_pkg::ST_IGNORE)
    else $error("ignored command left idle state");
  seq_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && rise && (state_r == sram_pkg::ST_WDATA || state_r == sram_pkg::ST_RDATA)
      && cnt_nxt == 6'(sram_pkg::INSTR_BITS) && op_mode_r == sram_pkg::MODE_SEQ && addr_r == sram_pkg::ADDR_LAST
      |=> addr_r == sram_pkg::ADDR_FIRST)
    else $error("sequential wrap wrong");
  page_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && rise && (state_r == sram_pkg::ST_WDATA || state_r == sram_pkg::ST_RDATA)
      && cnt_nxt == 6'(sram_pkg::INSTR_BITS) && op_mode_r == sram_pkg::MODE_PAGE
      && addr_r[sram_pkg::PAGE_BITS-1:0] == 5'h1f
      |=> addr_r == {$past(addr_r[sram_pkg::ADDR_BITS-1:sram_pkg::PAGE_BITS]), 5'h00})
    else $error("page wrap wrong");
  cs_end_a: assert property (@(posedge clk) disable iff (!rstn) ce && cs_n_s |=> state_r == sram_pkg::ST_CMD)
    else $error("operation not ended by deselect");
  standby_a: assert property (@(posedge clk) disable iff (!rstn) !started_r |-> state_r == sram_pkg::ST_CMD)
    else $error("activity before first select");
  pause_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && pause && width_r == sram_pkg::WIDTH_ONE |=> !wide_data_line_one_oe)
    else $error("output driven during pause");
endmodule : serial_sram_spi_slave

// ==== dv/spi_master_model.sv ====
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic       clk,
  input  wire logic [3:0] line,
  output logic            cs_n,
  output logic            sck,
  output logic [3:0]      m_oe,
  output logic [3:0]      m_d
);
  int w = 1;
  logic hold_n;
  initial
  begin
    hold_n = 1'b1;
    cs_n = 1'b1;
    sck  = 1'b0;
    m_oe = 4'b1101;
    m_d  = 4'b1100;
  end
  task sel();
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : sel
  // select stays low until the last unit is done
  task desel();
    @(posedge clk);
    sck <= 1'b0;
    repeat (6) @(posedge clk);
    cs_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask : desel
  // lanes 3 and 2 held high outside quad so pause stays off; wide reads release the lanes
  task xfer(input logic [31:0] tx, input int n, input bit drv, output logic [31:0] rx);
    logic [31:0] t;
    t  = tx;
    rx = '0;
    for (int i = 0; i < n / w; i++)
    begin
      @(posedge clk);
      sck  <= 1'b0;
      m_oe <= (w == 1) ? 4'b1101 : (w == 2) ? {2'b11, drv, drv} : {4{drv}};
      m_d  <= (w == 1) ? {hold_n, 2'b10, t[31]} : (w == 2) ? {2'b11, t[31:30]} : t[31:28];
      t = t << w;
      repeat (6) @(posedge clk);
      rx = (rx << w) | {28'h0, (w == 1) ? {3'b0, line[1]} : (w == 2) ? {2'b0, line[1:0]} : line};
      sck <= 1'b1;
      repeat (5) @(posedge clk);
    end
  endtask : xfer
  // pause pin on lane 3, single mode only; serial clock stands still meanwhile
  task hold(input logic lvl);
    @(posedge clk);
    hold_n <= lvl;
    m_d[3] <= lvl;
    repeat (8) @(posedge clk);
  endtask : hold
endmodule : spi_master_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        rstn = 1'b0;
  logic        flip = 1'b0;
  logic        cs_n;
  logic        sck;
  logic [3:0]  m_oe;
  logic [3:0]  m_d;
  logic [3:0]  d_oe;
  logic [3:0]  d_out;
  logic [3:0]  line;
  logic [1:0]  bus_width;
  logic [1:0]  access_mode;
  logic [31:0] r;
  int          err_count = 0;
  int          num_checks = 0;
  // released lines show a toggling level, never the last driven value
  assign line = (d_oe & d_out) | (~d_oe & m_oe & m_d) | (~d_oe & ~m_oe & {4{flip}});
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) flip <= ~flip;
  spi_master_model m (.clk(clk), .line(line), .cs_n(cs_n), .sck(sck), .m_oe(m_oe), .m_d(m_d));
  serial_sram_spi_slave DUT (
    .clk(clk), .rstn(rstn), .ce(1'b1), .chip_select_n(cs_n), .serial_clock(sck),
    .wide_data_line_zero_in(line[0]), .wide_data_line_zero_out(d_out[0]), .wide_data_line_zero_oe(d_oe[0]),
    .wide_data_line_one_in(line[1]), .wide_data_line_one_out(d_out[1]), .wide_data_line_one_oe(d_oe[1]),
    .wide_data_line_two_in(line[2]), .wide_data_line_two_out(d_out[2]), .wide_data_line_two_oe(d_oe[2]),
    .wide_data_line_three_in(line[3]), .wide_data_line_three_out(d_out[3]),
    .wide_data_line_three_oe(d_oe[3]), .bus_width(bus_width), .access_mode(access_mode));
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task cmd(input logic [7:0] c, input logic [23:0] a, input bit adr);
    m.sel();
    m.xfer({c, 24'h0}, 8, 1'b1, r);
    if (adr)
      m.xfer({a, 8'h0}, 24, 1'b1, r);
  endtask : cmd
  task wr(input logic [23:0] a, input logic [7:0] d[$]);
    cmd(sram_pkg::OP_WRITE, a, 1'b1);
    foreach (d[i])
      m.xfer({d[i], 24'h0}, 8, 1'b1, r);
    m.desel();
  endtask : wr
  task rd(input logic [23:0] a, input logic [7:0] e[$]);
    cmd(sram_pkg::OP_READ, a, 1'b1);
    foreach (e[i])
    begin
      m.xfer(32'h0, 8, 1'b0, r);
      chk("read data", e[i], r[7:0]);
    end
    m.desel();
    chk("output enable deselected", 8'h0, {4'h0, d_oe});
  endtask : rd
  task mwr(input logic [7:0] v);
    cmd(sram_pkg::OP_WRITE_MODE, 24'h0, 1'b0);
    m.xfer({v, 24'h0}, 8, 1'b1, r);
    m.desel();
  endtask : mwr
  task mrd(input logic [7:0] e);
    cmd(sram_pkg::OP_READ_MODE, 24'h0, 1'b0);
    m.xfer(32'h0, 8, 1'b0, r);
    m.desel();
    chk("mode register", e, r[7:0]);
  endtask : mrd
  task io(input logic [7:0] c, input int nw, input logic [1:0] ew);
    cmd(c, 24'h0, 1'b0);
    m.desel();
    m.w = nw;
    chk("bus width", {6'h0, ew}, {6'h0, bus_width});
  endtask : io
  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk("mode field", 8'h01, {6'h0, access_mode});
    m.xfer(32'h05000000, 8, 1'b1, r);
    chk("line one enable", 8'h0, {7'h0, d_oe[1]});
    m.desel();
    mrd(8'h40);
    $display("test reset done");
    wr(24'h000010, '{8'h11, 8'h22});
    mwr(8'h00);
    chk("mode field", 8'h00, {6'h0, access_mode});
    mrd(8'h00);
    wr(24'hfe0010, '{8'ha5, 8'h5a});
    mwr(8'h40);
    rd(24'h000010, '{8'ha5, 8'h22});
    cmd(sram_pkg::OP_READ, 24'h000010, 1'b1);
    m.xfer(32'h0, 8, 1'b0, r);
    m.hold(1'b0);
    chk("line one enable", 8'h00, {7'h0, d_oe[1]});
    m.hold(1'b1);
    chk("line one enable", 8'h01, {7'h0, d_oe[1]});
    m.xfer(32'h0, 8, 1'b0, r);
    chk("read data", 8'h22, r[7:0]);
    m.desel();
    $display("test byte done");
    wr(24'h01ffff, '{8'h77, 8'h88});
    rd(24'h01ffff, '{8'h77, 8'h88});
    rd(24'h000000, '{8'h88});
    $display("test sequential done");
    mwr(8'h80);
    mrd(8'h80);
    wr(24'h00003e, '{8'h01, 8'h02, 8'h03});
    rd(24'h00003f, '{8'h02, 8'h03});
    mwr(8'h40);
    wr(24'h000040, '{8'h44});
    rd(24'h00003f, '{8'h02, 8'h44});
    $display("test page done");
    cmd(8'h7e, 24'h0, 1'b0);
    m.xfer(32'h0, 16, 1'b0, r);
    chk("line one enable", 8'h0, {7'h0, d_oe[1]});
    m.desel();
    mrd(8'h40);
    for (int k = 0; k < 2; k++)
    begin
      io(k ? sram_pkg::OP_ENTER_FOUR : sram_pkg::OP_ENTER_TWO, k ? 4 : 2, k ? 2'h2 : 2'h1);
      wr(24'h000050 + k, '{8'hc3 ^ k[7:0]});
      rd(24'h000050 + k, '{8'hc3 ^ k[7:0]});
      io(sram_pkg::OP_RETURN_SINGLE, 1, 2'h0);
    end
    rd(24'h000050, '{8'hc3, 8'hc2});
    $display("test wide done");
    stop_test();
  end
  initial
  begin
    repeat (80000) @(posedge clk);
    err_count++;
    $display("ERROR watchdog expected finish seen timeout");
    stop_test();
  end
endmodule : tb_top
